// ### design/pfm_pkg.sv
// Purpose: shared constants and carrier types of the pin function mux
// Assumes: register index times four gives the APB byte address
// Notes:   all port registers reset to zero, so every pin outside the SPI/CAN port starts as GPIO
package pfm_pkg;

  // register indices on the APB word grid
  localparam logic [9:0] IDX_T_DATA    = 10'h000;
  localparam logic [9:0] IDX_T_LEVEL   = 10'h001;
  localparam logic [9:0] IDX_T_DIR     = 10'h002;
  localparam logic [9:0] IDX_T_REDUCED = 10'h003;
  localparam logic [9:0] IDX_T_PULL_EN = 10'h004;
  localparam logic [9:0] IDX_T_PULL_UP = 10'h005;
  localparam logic [9:0] IDX_ROUTING   = 10'h007;
  localparam logic [9:0] IDX_S_DATA    = 10'h008;
  localparam logic [9:0] IDX_S_DIR     = 10'h00A;
  localparam logic [9:0] IDX_P_DATA    = 10'h018;
  localparam logic [9:0] IDX_P_DIR     = 10'h01A;

  // port widths and field positions
  localparam int T_W        = 8;
  localparam int S_W        = 4;
  localparam int M_W        = 6;
  localparam int P_W        = 8;
  localparam int PWM_W      = 6;
  localparam int ROUTE_W    = 5;
  localparam int S_TX_BIT   = 1;
  localparam int S_RX_BIT   = 0;
  localparam int M_SPI_LSB  = 2;
  localparam int M_CANTX    = 1;
  localparam int M_CANRX    = 0;

  // reset values
  localparam logic [7:0] RST_PORT    = 8'h00;
  localparam logic [4:0] RST_ROUTING = 5'h00;

  // timer channels: ownership of the pin as output and the driven level
  typedef struct packed {
    logic [7:0] ch_own;
    logic [7:0] ch_out;
  } pfm_timer_t;

  // modulator channels: channel enabled and its output level
  typedef struct packed {
    logic [5:0] en;
    logic [5:0] out;
  } pfm_pwm_t;

  // asynchronous serial interface enables and transmit level
  typedef struct packed {
    logic tx_en;
    logic txd;
    logic rx_en;
  } pfm_sci_t;

  // spi pins ordered sck, mosi, ss, miso; can transmitter
  typedef struct packed {
    logic [3:0] spi_oe;
    logic [3:0] spi_out;
    logic       can_en;
    logic       can_tx;
  } pfm_spican_t;

  // electrical controls of the timer port pads
  typedef struct packed {
    logic [7:0] reduced;
    logic [7:0] pull_en;
    logic [7:0] pull_up;
  } pfm_tpad_t;

endpackage

// ### design/pfm_prio_mux.sv
// Purpose: three-level pin owner selection per bit
// Assumes: high and middle owners drive the pin as outputs
// Notes:   GPIO is the lowest level and wins when nobody else is enabled
`timescale 1ns/1ps
`default_nettype none
module pfm_prio_mux #(
  parameter int W = 8
) (
  // highest priority owner
  input  wire logic [W-1:0] hi_en,
  input  wire logic [W-1:0] hi_val,
  // middle priority owner
  input  wire logic [W-1:0] mid_en,
  input  wire logic [W-1:0] mid_val,
  // general-purpose fallback
  input  wire logic [W-1:0] lo_oe,
  input  wire logic [W-1:0] lo_val,
  // resolved pin drive
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe
);

  logic [W-1:0] mid_win;
  logic [W-1:0] lo_win;

  // top enabled owner takes the pin, then the next, then GPIO
  assign mid_win = ~hi_en & mid_en;
  assign lo_win  = ~hi_en & ~mid_en;
  assign pin_out = (hi_en & hi_val) | (mid_win & mid_val)
                 | (lo_win & lo_val);
  assign pin_oe  = hi_en | mid_en | (lo_win & lo_oe);

endmodule
`default_nettype wire

// ### design/pfm_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs come from pins outside the pclk domain
// Notes:   the level changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pfm_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // raw and filtered levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] agree;
  logic [W-1:0] q_next;

  // per bit, follow stage three only where it matches stage two
  assign agree  = ~(s2_reg ^ s3_reg);
  assign q_next = (agree & s3_reg) | (~agree & q_reg);
  assign q      = q_reg;

  // shift chain and filtered level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

endmodule
`default_nettype wire

// ### design/pfm_top.sv
// Purpose: pin function multiplexer and timer port register front end
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   pin drives are registered, so a change shows one cycle later
// Function
// - a shared pin goes to its highest-priority enabled function
// - timer port: routed modulator over timer channel over GPIO
// - after reset every multiplexed pin outside the SPI/CAN port works as GPIO
// - serial port bit 1 carries transmit when transmitter enabled
// - serial port bit 0 carries receive when receiver enabled
// - SPI/CAN port: sck 5, mosi 4, ss 3, miso 2, can tx 1, rx 0
// - modulator port: modulator outputs over GPIO, inputs feed interrupts
// - six timer port registers decoded at indices 0 to 5
// - routing register maps modulator channels onto timer port pins
// - a routed modulator channel shows on both ports at once
`timescale 1ns/1ps
`default_nettype none
module pfm_top
  import pfm_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // peripheral drive side
  input  wire pfm_timer_t        tim,
  input  wire pfm_pwm_t          pwm,
  input  wire pfm_sci_t          sci,
  input  wire pfm_spican_t       spican,
  // peripheral receive side
  output logic      [T_W-1:0]    timer_channel_in,
  output logic                   sci_rxd,
  output logic      [3:0]        spi_pin_in,
  output logic                   can_receive_line,
  output logic      [P_W-1:0]    pp_level,
  // timer port pins
  input  wire logic [T_W-1:0]    pt_in,
  output logic      [T_W-1:0]    pt_out,
  output logic      [T_W-1:0]    pt_oe,
  output pfm_tpad_t              pt_pad,
  // serial port pins
  input  wire logic [S_W-1:0]    ps_in,
  output logic      [S_W-1:0]    ps_out,
  output logic      [S_W-1:0]    ps_oe,
  // spi and can port pins
  input  wire logic [M_W-1:0]    pm_in,
  output logic      [M_W-1:0]    pm_out,
  output logic      [M_W-1:0]    pm_oe,
  // modulator port pins
  input  wire logic [P_W-1:0]    pp_in,
  output logic      [P_W-1:0]    pp_out,
  output logic      [P_W-1:0]    pp_oe
);

  // register hit test, shared by read and write decode
  function automatic logic hit(input logic [11:0] a,
                               input logic [9:0]  idx);
    hit = (a[1:0] == 2'h0) && (a[11:2] == idx);
  endfunction

  // software registers
  logic [T_W-1:0]     t_data_reg;
  logic [T_W-1:0]     t_dir_reg;
  logic [T_W-1:0]     t_reduced_reg;
  logic [T_W-1:0]     t_pull_en_reg;
  logic [T_W-1:0]     t_pull_up_reg;
  logic [ROUTE_W-1:0] modulator_routing_register;
  logic [S_W-1:0]     s_data_reg;
  logic [S_W-1:0]     s_dir_reg;
  logic [P_W-1:0]     p_data_reg;
  logic [P_W-1:0]     p_dir_reg;

  // apb answer registers
  logic [31:0]        prdata_reg;
  logic               pslverr_reg;
  logic [31:0]        rd_next;

  // synchronised pin levels
  logic [T_W-1:0]     t_level;
  logic [S_W-1:0]     s_level;
  logic [M_W-1:0]     m_level;
  logic [P_W-1:0]     p_level;

  // pin drive registers and their next values
  logic [T_W-1:0]     pt_out_reg;
  logic [T_W-1:0]     pt_oe_reg;
  logic [S_W-1:0]     ps_out_reg;
  logic [S_W-1:0]     ps_oe_reg;
  logic [M_W-1:0]     pm_out_reg;
  logic [M_W-1:0]     pm_oe_reg;
  logic [P_W-1:0]     pp_out_reg;
  logic [P_W-1:0]     pp_oe_reg;
  logic [T_W-1:0]     pt_out_next;
  logic [T_W-1:0]     pt_oe_next;
  logic [S_W-1:0]     ps_out_next;
  logic [S_W-1:0]     ps_oe_next;
  logic [M_W-1:0]     pm_out_next;
  logic [M_W-1:0]     pm_oe_next;
  logic [P_W-1:0]     pp_out_next;
  logic [P_W-1:0]     pp_oe_next;

  // owner enables per port
  logic [T_W-1:0]     t_route_en;
  logic [T_W-1:0]     t_route_val;
  logic [S_W-1:0]     s_hi_en;
  logic [S_W-1:0]     s_hi_val;
  logic [S_W-1:0]     s_gpio_oe;
  logic [P_W-1:0]     p_hi_en;
  logic [P_W-1:0]     p_hi_val;

  // address decode
  logic sel_t_data;
  logic sel_t_level;
  logic sel_t_dir;
  logic sel_t_reduced;
  logic sel_t_pull_en;
  logic sel_t_pull_up;
  logic sel_routing;
  logic sel_s_data;
  logic sel_s_dir;
  logic sel_p_data;
  logic sel_p_dir;
  logic mapped;
  logic setup;
  logic wr;

  assign sel_t_data    = hit(paddr, IDX_T_DATA);
  assign sel_t_level   = hit(paddr, IDX_T_LEVEL);
  assign sel_t_dir     = hit(paddr, IDX_T_DIR);
  assign sel_t_reduced = hit(paddr, IDX_T_REDUCED);
  assign sel_t_pull_en = hit(paddr, IDX_T_PULL_EN);
  assign sel_t_pull_up = hit(paddr, IDX_T_PULL_UP);
  assign sel_routing   = hit(paddr, IDX_ROUTING);
  assign sel_s_data    = hit(paddr, IDX_S_DATA);
  assign sel_s_dir     = hit(paddr, IDX_S_DIR);
  assign sel_p_data    = hit(paddr, IDX_P_DATA);
  assign sel_p_dir     = hit(paddr, IDX_P_DIR);
  assign mapped = sel_t_data | sel_t_level | sel_t_dir | sel_t_reduced
                | sel_t_pull_en | sel_t_pull_up | sel_routing
                | sel_s_data | sel_s_dir | sel_p_data | sel_p_dir;

  // setup phase captures the answer; access phase completes at once
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & mapped;
  assign pready  = psel & penable;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // read selection, narrow registers sit in the low bits
  assign rd_next =
      sel_t_data    ? {24'h000000, t_data_reg}    :
      sel_t_level   ? {24'h000000, t_level}       :
      sel_t_dir     ? {24'h000000, t_dir_reg}     :
      sel_t_reduced ? {24'h000000, t_reduced_reg} :
      sel_t_pull_en ? {24'h000000, t_pull_en_reg} :
      sel_t_pull_up ? {24'h000000, t_pull_up_reg} :
      sel_routing   ? {27'h0000000, modulator_routing_register} :
      sel_s_data    ? {28'h0000000, s_data_reg}   :
      sel_s_dir     ? {28'h0000000, s_dir_reg}    :
      sel_p_data    ? {24'h000000, p_data_reg}    :
      sel_p_dir     ? {24'h000000, p_dir_reg}     :
      32'h00000000;

  // answer registers, loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg  <= pwrite ? 32'h00000000 : rd_next;
      pslverr_reg <= ~mapped;
    end
  end

  // register writes; the input level register has no write path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_data_reg    <= RST_PORT;
      t_dir_reg     <= RST_PORT;
      t_reduced_reg <= RST_PORT;
      t_pull_en_reg <= RST_PORT;
      t_pull_up_reg <= RST_PORT;
      modulator_routing_register <= RST_ROUTING;
      s_data_reg    <= RST_PORT[S_W-1:0];
      s_dir_reg     <= RST_PORT[S_W-1:0];
      p_data_reg    <= RST_PORT;
      p_dir_reg     <= RST_PORT;
    end else if (wr) begin
      if (sel_t_data) begin
        t_data_reg <= pwdata[T_W-1:0];
      end else if (sel_t_dir) begin
        t_dir_reg <= pwdata[T_W-1:0];
      end else if (sel_t_reduced) begin
        t_reduced_reg <= pwdata[T_W-1:0];
      end else if (sel_t_pull_en) begin
        t_pull_en_reg <= pwdata[T_W-1:0];
      end else if (sel_t_pull_up) begin
        t_pull_up_reg <= pwdata[T_W-1:0];
      end else if (sel_routing) begin
        modulator_routing_register <= pwdata[ROUTE_W-1:0];
      end else if (sel_s_data) begin
        s_data_reg <= pwdata[S_W-1:0];
      end else if (sel_s_dir) begin
        s_dir_reg <= pwdata[S_W-1:0];
      end else if (sel_p_data) begin
        p_data_reg <= pwdata[P_W-1:0];
      end else if (sel_p_dir) begin
        p_dir_reg <= pwdata[P_W-1:0];
      end
    end
  end

  // pin input synchronisers
  pfm_sync #(.W(T_W)) u_sync_t (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pt_in),
    .q       (t_level)
  );
  pfm_sync #(.W(S_W)) u_sync_s (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (ps_in),
    .q       (s_level)
  );
  pfm_sync #(.W(M_W)) u_sync_m (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pm_in),
    .q       (m_level)
  );
  pfm_sync #(.W(P_W)) u_sync_p (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pp_in),
    .q       (p_level)
  );

  // timer port: routed modulator channels sit above the timer
  assign t_route_en  = {3'h0, modulator_routing_register
                        & pwm.en[ROUTE_W-1:0]};
  assign t_route_val = {3'h0, pwm.out[ROUTE_W-1:0]};

  pfm_prio_mux #(.W(T_W)) u_mux_t (
    .hi_en   (t_route_en),
    .hi_val  (t_route_val),
    .mid_en  (tim.ch_own),
    .mid_val (tim.ch_out),
    .lo_oe   (t_dir_reg),
    .lo_val  (t_data_reg),
    .pin_out (pt_out_next),
    .pin_oe  (pt_oe_next)
  );

  // serial port: transmit on bit 1, receive frees bit 0 as input
  assign s_hi_en   = {2'h0, sci.tx_en, 1'b0};
  assign s_hi_val  = {2'h0, sci.txd, 1'b0};
  assign s_gpio_oe = s_dir_reg & ~{3'h0, sci.rx_en};

  pfm_prio_mux #(.W(S_W)) u_mux_s (
    .hi_en   (s_hi_en),
    .hi_val  (s_hi_val),
    .mid_en  ({S_W{1'b0}}),
    .mid_val ({S_W{1'b0}}),
    .lo_oe   (s_gpio_oe),
    .lo_val  (s_data_reg),
    .pin_out (ps_out_next),
    .pin_oe  (ps_oe_next)
  );

  // modulator port: channels drive whether or not also routed
  assign p_hi_en  = {2'h0, pwm.en};
  assign p_hi_val = {2'h0, pwm.out};

  pfm_prio_mux #(.W(P_W)) u_mux_p (
    .hi_en   (p_hi_en),
    .hi_val  (p_hi_val),
    .mid_en  ({P_W{1'b0}}),
    .mid_val ({P_W{1'b0}}),
    .lo_oe   (p_dir_reg),
    .lo_val  (p_data_reg),
    .pin_out (pp_out_next),
    .pin_oe  (pp_oe_next)
  );

  // spi and can port: fixed pin assignment, receive line input only
  assign pm_out_next = {spican.spi_out, spican.can_tx, 1'b0};
  assign pm_oe_next  = {spican.spi_oe, spican.can_en, 1'b0};

  // levels handed back to the peripherals
  assign timer_channel_in = t_level;
  assign sci_rxd          = sci.rx_en ? s_level[S_RX_BIT]
                                      : 1'b1;
  assign spi_pin_in       = m_level[M_W-1:M_SPI_LSB];
  assign can_receive_line = m_level[M_CANRX];
  assign pp_level         = p_level;

  // registered pin drive, all released to input at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_out_reg <= '0;
      pt_oe_reg  <= '0;
      ps_out_reg <= '0;
      ps_oe_reg  <= '0;
      pm_out_reg <= '0;
      pm_oe_reg  <= '0;
      pp_out_reg <= '0;
      pp_oe_reg  <= '0;
    end else begin
      pt_out_reg <= pt_out_next;
      pt_oe_reg  <= pt_oe_next;
      ps_out_reg <= ps_out_next;
      ps_oe_reg  <= ps_oe_next;
      pm_out_reg <= pm_out_next;
      pm_oe_reg  <= pm_oe_next;
      pp_out_reg <= pp_out_next;
      pp_oe_reg  <= pp_oe_next;
    end
  end

  // pin and pad outputs
  assign pt_out         = pt_out_reg;
  assign pt_oe          = pt_oe_reg;
  assign ps_out         = ps_out_reg;
  assign ps_oe          = ps_oe_reg;
  assign pm_out         = pm_out_reg;
  assign pm_oe          = pm_oe_reg;
  assign pp_out         = pp_out_reg;
  assign pp_oe          = pp_oe_reg;
  assign pt_pad.reduced = t_reduced_reg;
  assign pt_pad.pull_en = t_pull_en_reg;
  assign pt_pad.pull_up = t_pull_up_reg;

endmodule
`default_nettype wire

// ### verification/pfm_checker.sv
// Purpose: port-level checks of the pin function mux
// Assumes: pin drives are registered one edge after their cause
// Notes:   routing register is not visible here; the bench covers it
`timescale 1ns/1ps
`default_nettype none
module pfm_checker
  import pfm_pkg::*;
(
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // peripheral drive
  input wire pfm_timer_t  tim,
  input wire pfm_pwm_t    pwm,
  input wire pfm_sci_t    sci,
  input wire pfm_spican_t spican,
  // pins and synced levels
  input wire logic [7:0]  pt_out,
  input wire logic [7:0]  pt_oe,
  input wire logic [3:0]  ps_in,
  input wire logic [3:0]  ps_out,
  input wire logic [3:0]  ps_oe,
  input wire logic [5:0]  pm_in,
  input wire logic [5:0]  pm_out,
  input wire logic [5:0]  pm_oe,
  input wire logic        sci_rxd,
  input wire logic        can_receive_line,
  input wire logic [7:0]  pp_out,
  input wire logic [7:0]  pp_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answers and refusals
  a_ready_zero_wait:
    assert property (psel && penable |-> pready)
    else $error("pready missing in access cycle");
  a_unaligned_err:
    assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  a_unmapped_err:
    assert property (psel && !penable && paddr[11:2] == 10'h006 |=> pslverr)
    else $error("unmapped access not refused");
  // timer port ownership
  a_timer_high_pin:
    assert property (tim.ch_own[7] |=> pt_oe[7] &&
      pt_out[7] == $past(tim.ch_out[7])) else $error("timer lost pin 7");
  a_timer_over_gpio:
    assert property (tim.ch_own[0] && !pwm.en[0]
      |=> pt_oe[0] && pt_out[0] == $past(tim.ch_out[0]))
    else $error("timer lost pin 0");
  // modulator port
  a_pwm_port_wins:
    assert property (|pwm.en |=>
      (pp_oe[5:0] & $past(pwm.en)) == $past(pwm.en) &&
      ((pp_out[5:0] ^ $past(pwm.out)) & $past(pwm.en)) == 6'h00)
    else $error("modulator lost its port pin");
  // serial port
  a_tx_owns_bit1:
    assert property (sci.tx_en |=> ps_oe[1] &&
      ps_out[1] == $past(sci.txd)) else $error("transmit not on bit 1");
  a_rx_bit0_input:
    assert property (sci.rx_en |=> !ps_oe[0])
    else $error("receive pin driven");
  a_rx_follows_pin:
    assert property ((sci.rx_en && $stable(ps_in[0]))[*6]
      |-> sci_rxd == ps_in[0]) else $error("receive level wrong");
  // spi and can port
  a_spi_sck_bit5:
    assert property (spican.spi_oe[3] |=> pm_oe[5] &&
      pm_out[5] == $past(spican.spi_out[3])) else $error("sck not on bit 5");
  a_can_tx_bit1:
    assert property (spican.can_en |=> pm_oe[1] &&
      pm_out[1] == $past(spican.can_tx)) else $error("can tx not on bit 1");
  a_can_rx_input:
    assert property ($stable(pm_in[0])[*6] |->
      !pm_oe[0] && can_receive_line == pm_in[0]) else $error("can rx wrong");
  // main scenarios reached
  c_refused: cover property (pslverr);
  c_pwm_timer: cover property (|pwm.en && |tim.ch_own);
  c_serial: cover property (sci.tx_en && sci.rx_en);
endmodule
bind pfm_top pfm_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .tim, .pwm, .sci, .spican, .pt_out, .pt_oe, .ps_in,
  .ps_out, .ps_oe, .pm_in, .pm_out, .pm_oe, .sci_rxd, .can_receive_line,
  .pp_out, .pp_oe);
`default_nettype wire

// ### verification/pfm_pin_world.sv
// Purpose: pin-side model of one port: resolves each pad level
// Assumes: testbench avoids driving a pin the block already drives, except serial bit 0 after its direction is set and before receive is enabled
// Notes:   a floating pin with no pull shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_world #(
  parameter int W = 8
) (
  // clock
  input  wire logic         clk,
  // block drive, outside drive and pad pulls
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] ext_v,
  input  wire logic [W-1:0] ext_e,
  input  wire logic [W-1:0] pull_en,
  input  wire logic [W-1:0] pull_up,
  // resolved pad level
  output logic      [W-1:0] pin
);
  logic [W-1:0] last;
  initial last = '0;
  // owner drive first, then outside driver, then pull, else drifting level
  assign pin = (oe & out) | (~oe & ext_e & ext_v)
             | (~oe & ~ext_e & pull_en & pull_up)
             | (~oe & ~ext_e & ~pull_en & ~last);
  // remember level so a floating pin keeps changing
  always @(posedge clk) begin
    last <= pin;
  end
endmodule
`default_nettype wire

// ### verification/tb_port_pin_function_mux.sv
// Purpose: self-checking bench of the pin function mux
// Assumes: zero-wait apb slave, pin drive one edge after its cause
// Notes:   pin levels come from the pin world model of each port
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_function_mux
  import pfm_pkg::*;
;
  logic        pclk = 0, presetn = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, sci_rxd, can_receive_line;
  pfm_timer_t  tim = '0;
  pfm_pwm_t    pwm = '0;
  pfm_sci_t    sci = '0;
  pfm_spican_t spican = '0;
  pfm_tpad_t   pt_pad;
  logic [7:0]  timer_channel_in, pp_level, pt_in, pt_out, pt_oe;
  logic [7:0]  pp_in, pp_out, pp_oe, t_xv = '0, t_xe = '0;
  logic [7:0]  p_xv = '0, p_xe = '0;
  logic [7:0]  x_pe = '0, x_pu = '0;
  logic [3:0]  spi_pin_in, ps_in, ps_out, ps_oe, s_xv = '0, s_xe = '0;
  logic [5:0]  pm_in, pm_out, pm_oe, m_xv = '0, m_xe = 6'h01;
  int          error_cnt = 0, tests_run = 0;
  always #5 pclk = ~pclk;
  pfm_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tim, .pwm, .sci, .spican, .timer_channel_in,
    .sci_rxd, .spi_pin_in, .can_receive_line, .pp_level, .pt_in, .pt_out,
    .pt_oe, .pt_pad, .ps_in, .ps_out, .ps_oe, .pm_in, .pm_out, .pm_oe, .pp_in,
    .pp_out, .pp_oe);
  pfm_pin_world #(.W(8)) u_pt (.clk(pclk), .out(pt_out), .oe(pt_oe),
    .ext_v(t_xv), .ext_e(t_xe), .pull_en(pt_pad.pull_en),
    .pull_up(pt_pad.pull_up), .pin(pt_in));
  pfm_pin_world #(.W(4)) u_ps (.clk(pclk), .out(ps_out), .oe(ps_oe),
    .ext_v(s_xv), .ext_e(s_xe), .pull_en(x_pe[3:0]), .pull_up(x_pu[3:0]),
    .pin(ps_in));
  pfm_pin_world #(.W(6)) u_pm (.clk(pclk), .out(pm_out), .oe(pm_oe),
    .ext_v(m_xv), .ext_e(m_xe), .pull_en(x_pe[5:0]), .pull_up(x_pu[5:0]),
    .pin(pm_in));
  pfm_pin_world #(.W(8)) u_pp (.clk(pclk), .out(pp_out), .oe(pp_oe),
    .ext_v(p_xv), .ext_e(p_xe), .pull_en(x_pe), .pull_up(x_pu), .pin(pp_in));
  // verdict and end of run
  task final_report;
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      final_report;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] x,
          input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(nm, r, x);
    check("pslverr", e, xe);
  endtask
  task waitc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // reset values of timer port and routing registers, gpio oe of timer, serial and modulator ports
  task t_reset;
    logic [11:0] al [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                            12'h014, 12'h01C};
    foreach (al[i]) rd("reset reg", al[i], 32'h0, 1'b0);
    check("oe after reset", {pt_oe, pp_oe, ps_oe}, 32'h0);
  endtask
  // pad registers, refused unmapped read, dropped unaligned write
  task t_regs;
    wr(12'h00C, 8'h5A);
    wr(12'h010, 8'h3C);
    wr(12'h014, 8'hC3);
    rd("reduced", 12'h00C, 32'h5A, 1'b0);
    rd("pull_en", 12'h010, 32'h3C, 1'b0);
    rd("pull_up", 12'h014, 32'hC3, 1'b0);
    check("pads", pt_pad, 24'h5A3CC3);
    rd("unmapped", 12'h018, 32'h0, 1'b1);
    wr(12'h002, 8'hFF);
    rd("unaligned", 12'h000, 32'h0, 1'b0);
  endtask
  // gpio drive and synced level readback
  task t_gpio;
    t_xe <= 8'hF0;
    t_xv <= 8'hA0;
    wr(12'h008, 8'h0F);
    wr(12'h000, 8'h05);
    wr(12'h004, 8'hFF);
    waitc(6);
    check("gpio oe", pt_oe, 8'h0F);
    check("gpio out", pt_out & 8'h0F, 8'h05);
    check("timer in", timer_channel_in, 8'hA5);
    rd("level", 12'h004, 32'hA5, 1'b0);
    rd("data", 12'h000, 32'h05, 1'b0);
  endtask
  // routed modulator over timer over gpio, shown on both ports
  task t_prio;
    t_xe <= 8'h00;
    tim <= '{ch_own: 8'h8F, ch_out: 8'h8A};
    pwm <= '{en: 6'h03, out: 6'h01};
    wr(12'h01C, 8'h01);
    waitc(2);
    check("prio oe", {pt_oe[7], pt_oe[3:0]}, 5'h1F);
    check("prio out", pt_out[3:0], 4'hB);
    check("both ports", {pp_oe[1:0], pp_out[1:0]}, 4'hD);
    wr(12'h01C, 8'h00);
    waitc(2);
    check("unrouted", pt_out[3:0], 4'hA);
    @(posedge pclk);
    pwm <= '0;
    waitc(2);
    check("timer only", {pt_oe[3:0], pt_out[3:0]}, 8'hFA);
    @(posedge pclk);
    tim <= '0;
  endtask
  // serial port: transmit and receive take their bits
  task t_serial;
    s_xe <= 4'h1;
    wr(12'h028, 8'h03);
    wr(12'h020, 8'h03);
    sci <= '{tx_en: 1'b1, txd: 1'b0, rx_en: 1'b1};
    waitc(6);
    check("sci oe", ps_oe[1:0], 2'h2);
    check("txd", ps_out[1], 1'b0);
    check("rxd", sci_rxd, 1'b0);
    @(posedge pclk);
    s_xe <= 4'h0;
    sci <= '0;
    waitc(2);
    check("sci gpio", {ps_oe[1:0], ps_out[1:0]}, 4'hF);
    check("rxd idle", sci_rxd, 1'b1);
  endtask
  // spi and can bit map
  task t_spican;
    @(posedge pclk);
    spican <= '{spi_oe: 4'hF, spi_out: 4'hA, can_en: 1'b1, can_tx: 1'b1};
    waitc(6);
    check("pm oe", pm_oe, 6'h3E);
    check("pm out", pm_out[5:1], 5'h15);
    check("spi in", spi_pin_in, 4'hA);
    check("can rx", can_receive_line, 1'b0);
    @(posedge pclk);
    m_xv <= 6'h01;
    waitc(6);
    check("can rx hi", can_receive_line, 1'b1);
    @(posedge pclk);
    spican <= '0;
  endtask
  // modulator port drive with gpio left as input, levels feed interrupt logic
  task t_pwm_port;
    p_xe <= 8'h80;
    p_xv <= 8'h80;
    x_pe <= 8'h40;
    x_pu <= 8'h40;
    pwm <= '{en: 6'h3F, out: 6'h2A};
    waitc(6);
    check("pp oe", pp_oe, 8'h3F);
    check("pp out", pp_out[5:0], 6'h2A);
    check("pp level", pp_level, 8'hEA);
  endtask
  // bound on the whole run
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_gpio;
    t_prio;
    t_serial;
    t_spican;
    t_pwm_port;
    final_report;
  end
endmodule
`default_nettype wire
